// ---- inc/cdsx_pkg.sv ----
package cdsx_pkg;

    // ----------------------------------------
    // Instruction word layout
    // ----------------------------------------
    localparam int INSN_W = 12;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 5;
    localparam int DEST_BIT = 5;
    localparam int ADDR_LSB = 0;
    localparam int OPC_LSB = 6;
    localparam int OPC_W = 6;

    // ----------------------------------------
    // Opcodes, bits 11:6 of the word
    // ----------------------------------------
    localparam logic [5:0] OPC_INVERT = 6'h09;
    localparam logic [5:0] OPC_DECR = 6'h03;
    localparam logic [5:0] OPC_DECR_SKIP = 6'h0B;

    // ----------------------------------------
    // Values after reset and cycle counts
    // ----------------------------------------
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic ZERO_RESET = 1'b0;
    localparam logic [7:0] RES_RESET = 8'h00;
    localparam logic [4:0] WBA_RESET = 5'h00;
    localparam logic [7:0] FILE_RESET = 8'h00;
    localparam int SKIP_CYCLES = 1;

    // Execute stage states
    typedef enum logic [1:0] {
        CDSX_RUN = 2'b01,
        CDSX_SKIP = 2'b10
    } cdsx_state_e;

endpackage

// ---- inc/cdsx_rf_if.sv ----
`timescale 1ns/1ns
// Register file port shared by the executer and the file
interface cdsx_rf_if;
    logic [4:0] addr;
    logic [7:0] rdata;
    logic [7:0] wdata;
    logic we;

    modport core (output addr, output wdata, output we, input rdata);
    modport file (input addr, input wdata, input we, output rdata);
endinterface

// ---- logic/cdsx_regfile.sv ----
`timescale 1ns/1ns
module cdsx_regfile #(
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Access port
    cdsx_rf_if.file rf
);

    // Address field is five bits, so the file must cover all 32 codes
    if (DEPTH != 32) begin : g_depth_bad
        $error("cdsx_regfile: DEPTH must be 32");
    end

    logic [7:0] mem_reg [DEPTH];
    logic [7:0] mem_next [DEPTH];

    // Combinational read; address field covers every location
    assign rf.rdata = mem_reg[rf.addr];

    // Next contents
    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            mem_next[i] = mem_reg[i];
        end
        if (rf.we) begin
            mem_next[rf.addr] = rf.wdata;
        end
    end

    // Storage; cleared so contents are defined after reset
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= cdsx_pkg::FILE_RESET;
            end
        end else begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= mem_next[i];
            end
        end
    end
endmodule

// ---- logic/cdsx_exec.sv ----
`timescale 1ns/1ns
// Contract
// - Invert pattern writes complement of selected register, one cycle.
// - Destination bit 0 writes accumulator, bit 1 writes back to register.
// - Decrement pattern writes register minus one, one cycle.
// - Decrement-skip stores minus one, discards next word on zero, no flags.
// - Taken skip runs a no-operation on the next valid word instead; two cycles unless the fetch slot stalls.
module cdsx_exec (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Instruction stream
    input wire logic [11:0] insn,
    input wire logic insn_valid,
    // Observed core state
    output logic [7:0] acc,
    output logic zero_flag,
    output logic skip_taken,
    output logic executed,
    output logic [7:0] result,
    output logic [4:0] wb_addr,
    output logic wb_we
);

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    cdsx_rf_if rf ();

    logic [5:0] opc;
    logic dest;
    logic is_inv;
    logic is_dec;
    logic is_dsz;
    logic [7:0] alu;

    assign opc = insn[cdsx_pkg::OPC_LSB +: cdsx_pkg::OPC_W];
    assign dest = insn[cdsx_pkg::DEST_BIT];
    assign rf.addr = insn[cdsx_pkg::ADDR_LSB +: cdsx_pkg::ADDR_W];
    assign is_inv = (opc == cdsx_pkg::OPC_INVERT);
    assign is_dec = (opc == cdsx_pkg::OPC_DECR);
    assign is_dsz = (opc == cdsx_pkg::OPC_DECR_SKIP);

    cdsx_regfile #(
        .DEPTH(32)
    ) u_file (
        .ref_clk(ref_clk),
        .rst(rst),
        .rf(rf)
    );

    // ----------------------------------------
    // Elaboration checks
    // ----------------------------------------
    // Ports and the file interface are sized for the fixed word layout;
    // a package edit that lets fields overlap is refused here instead
    // of quietly decoding the wrong bits
    localparam int OPC_TOP = cdsx_pkg::OPC_LSB + cdsx_pkg::OPC_W;
    localparam int ADDR_TOP = cdsx_pkg::ADDR_LSB + cdsx_pkg::ADDR_W;

    if (cdsx_pkg::INSN_W != 12) begin : g_word_bad
        $error("cdsx_exec: instruction word must be 12 bits");
    end
    if (cdsx_pkg::DATA_W != 8) begin : g_data_bad
        $error("cdsx_exec: data path must be 8 bits");
    end
    if (cdsx_pkg::ADDR_W != 5) begin : g_addr_bad
        $error("cdsx_exec: register address must be 5 bits");
    end
    if (OPC_TOP != cdsx_pkg::INSN_W) begin : g_opc_bad
        $error("cdsx_exec: opcode field must end at the word top");
    end
    if (ADDR_TOP > cdsx_pkg::DEST_BIT) begin : g_dest_bad
        $error("cdsx_exec: address field overlaps destination bit");
    end
    if (cdsx_pkg::DEST_BIT >= cdsx_pkg::OPC_LSB) begin : g_bit_bad
        $error("cdsx_exec: destination bit overlaps opcode field");
    end

    // ----------------------------------------
    // State
    // ----------------------------------------
    cdsx_pkg::cdsx_state_e state_reg, state_next;
    logic [7:0] acc_reg, acc_next;
    logic zero_reg, zero_next;
    logic skip_reg, skip_next;
    logic exec_reg, exec_next;
    logic [7:0] res_reg, res_next;
    logic [4:0] wba_reg, wba_next;
    logic wbwe_reg, wbwe_next;
    logic act;
    logic file_we;
    logic alu_zero;
    logic skip_due;

    // ----------------------------------------
    // Arithmetic
    // ----------------------------------------
    // One inverter and one subtractor serve all three operations; the
    // opcode only steers which of the two reaches the write port
    always_comb begin
        if (is_inv) begin
            alu = ~rf.rdata;
        end else begin
            alu = rf.rdata - 8'h01;
        end
    end

    // Zero test shared by the flag and the skip decision
    assign alu_zero = (alu == 8'h00);

    // ----------------------------------------
    // Write port
    // ----------------------------------------
    // Discarded word never reaches the file or the accumulator, so an
    // operation is only taken in the run state
    assign act = insn_valid && (state_reg == cdsx_pkg::CDSX_RUN) &&
                 (is_inv || is_dec || is_dsz);
    // The write lands on the taking edge; the read port is
    // combinational, so a back-to-back op on one address sees it
    assign file_we = act && dest;
    assign rf.we = file_we;
    assign rf.wdata = alu;
    // Only a decrement-skip with a zero result opens the skip slot
    assign skip_due = act && is_dsz && alu_zero;

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    // Next state: one word per cycle, skip slot consumes one word.
    // Pulses default low so each one stands for a single cycle only
    always_comb begin
        state_next = state_reg;
        skip_next = 1'b0;
        exec_next = 1'b0;
        wbwe_next = 1'b0;
        unique case (state_reg)
            cdsx_pkg::CDSX_RUN: begin
                if (act) begin
                    exec_next = 1'b1;
                    wbwe_next = dest;
                end
                if (skip_due) begin
                    state_next = cdsx_pkg::CDSX_SKIP;
                end
            end
            cdsx_pkg::CDSX_SKIP: begin
                // Fetched word is dropped; a no-operation runs instead.
                // An empty fetch slot waits, so the skip always costs
                // a word and not merely a clock
                if (insn_valid) begin
                    skip_next = 1'b1;
                    state_next = cdsx_pkg::CDSX_RUN;
                end
            end
            default: begin
                // An upset code falls back to run rather than lock up
                state_next = cdsx_pkg::CDSX_RUN;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_reg <= cdsx_pkg::CDSX_RUN;
            skip_reg <= 1'b0;
            exec_reg <= 1'b0;
            wbwe_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            skip_reg <= skip_next;
            exec_reg <= exec_next;
            wbwe_reg <= wbwe_next;
        end
    end

    // ----------------------------------------
    // Datapath
    // ----------------------------------------
    // Accumulator, flag and write-back trace; all hold between ops so
    // the outside can read the last result at leisure
    always_comb begin
        acc_next = acc_reg;
        zero_next = zero_reg;
        res_next = res_reg;
        wba_next = wba_reg;
        if (act) begin
            res_next = alu;
            wba_next = rf.addr;
            if (!dest) begin
                acc_next = alu;
            end
            // Skip opcode leaves status alone
            if (is_inv || is_dec) begin
                zero_next = alu_zero;
            end
        end
    end

    // Datapath registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            acc_reg <= cdsx_pkg::ACC_RESET;
            zero_reg <= cdsx_pkg::ZERO_RESET;
            res_reg <= cdsx_pkg::RES_RESET;
            wba_reg <= cdsx_pkg::WBA_RESET;
        end else begin
            acc_reg <= acc_next;
            zero_reg <= zero_next;
            res_reg <= res_next;
            wba_reg <= wba_next;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Outputs straight from flip-flops, so no decode glitch can reach
    // the pins of the block
    assign acc = acc_reg;
    assign zero_flag = zero_reg;
    assign skip_taken = skip_reg;
    assign executed = exec_reg;
    assign result = res_reg;
    assign wb_addr = wba_reg;
    assign wb_we = wbwe_reg;
endmodule

// ---- tb/cdsx_prog_mem.sv ----
`timescale 1ns/1ns
// Program memory; an idle bus shows a scrambled word, never a stale one
module cdsx_prog_mem (
    // Fetch
    input wire logic [11:0] word,
    input wire logic fetch,
    // Bus
    output logic [11:0] insn,
    output logic insn_valid
);
    assign insn = fetch ? word : ~word;
    assign insn_valid = fetch;
endmodule

// ---- tb/cdsx_exec_sva.sv ----
`timescale 1ns/1ns
module cdsx_exec_sva (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Watched ports
    input wire logic [11:0] insn,
    input wire logic insn_valid,
    input wire logic [7:0] acc,
    input wire logic zero_flag,
    input wire logic skip_taken,
    input wire logic executed,
    input wire logic [7:0] result,
    input wire logic [4:0] wb_addr,
    input wire logic wb_we
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Skipping op just ran, and its opposite
    sequence skip_op_s;
        executed && $past(insn[11:6]) == cdsx_pkg::OPC_DECR_SKIP;
    endsequence
    sequence plain_op_s;
        executed && $past(insn[11:6]) != cdsx_pkg::OPC_DECR_SKIP;
    endsequence
    dest_sel_a: assert property (
        executed |-> wb_we == $past(insn[5])) else $error("dest bit");
    acc_load_a: assert property (
        executed && !wb_we |-> acc == result) else $error("acc load");
    wb_addr_a: assert property (
        executed |-> wb_addr == $past(insn[4:0])) else $error("addr");
    zero_set_a: assert property (
        plain_op_s |-> zero_flag == (result == 8'h00)) else $error("zf");
    zero_keep_a: assert property (
        skip_op_s |-> $stable(zero_flag)) else $error("zf kept");
    skip_due_a: assert property (
        skip_op_s ##0 result == 8'h00 && insn_valid |=> skip_taken)
        else $error("no skip");
    nop_run_a: assert property (
        skip_taken |-> !executed && !wb_we && $stable(acc))
        else $error("nop");
endmodule
bind cdsx_exec cdsx_exec_sva chk_i (.ref_clk, .rst, .insn, .insn_valid,
    .acc, .zero_flag, .skip_taken, .executed, .result, .wb_addr, .wb_we);

// ---- tb/cdsx_exec_test.sv ----
`timescale 1ns/1ns
module cdsx_exec_test;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] word = 12'h000;
    logic fetch = 1'b0;
    logic [11:0] insn;
    logic insn_valid, zero_flag, skip_taken, executed, wb_we;
    logic [7:0] acc, result, e_acc, e_res;
    logic [4:0] wb_addr;
    logic [7:0] mem [32];
    logic e_z, e_sk, e_ex, e_we, skip;
    logic [4:0] e_wa;
    logic [5:0] op;
    logic [11:0] w_rand;
    // Hand-picked words that walk a register down to zero and skip
    logic [11:0] corner [5] = '{12'h27F, 12'h262, 12'h0E2, 12'h262, 12'h2E2};
    int bad_count = 0;
    int check_count = 0;
    // Free-running clock
    always #2 ref_clk = ~ref_clk;
    cdsx_prog_mem pm (.word, .fetch, .insn, .insn_valid);
    cdsx_exec uut (.ref_clk, .rst, .insn, .insn_valid, .acc, .zero_flag,
        .skip_taken, .executed, .result, .wb_addr, .wb_we);
    task chk(string n, logic [7:0] e, logic [7:0] g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask
    function automatic logic [7:0] calc(logic [11:0] w, logic [7:0] v);
        return w[11:6] == cdsx_pkg::OPC_INVERT ? ~v : v - 8'h01;
    endfunction
    // Drive one word, check the previous one, then model this one
    task step(logic [11:0] w, logic v);
        logic [7:0] r;
        @(posedge ref_clk);
        word <= w;
        fetch <= v;
        #1;
        chk("acc", e_acc, acc);
        chk("zero", 8'(e_z), 8'(zero_flag));
        chk("skip", 8'(e_sk), 8'(skip_taken));
        chk("exec", 8'(e_ex), 8'(executed));
        chk("we", 8'(e_we), 8'(wb_we));
        chk("result", e_res, result);
        chk("addr", 8'(e_wa), 8'(wb_addr));
        {e_sk, e_ex, e_we} = 3'b000;
        if (v && skip) begin
            {skip, e_sk} = 2'b01;
        end else if (v && w[11:6] inside {cdsx_pkg::OPC_INVERT,
                cdsx_pkg::OPC_DECR, cdsx_pkg::OPC_DECR_SKIP}) begin
            r = calc(w, mem[w[4:0]]);
            {e_ex, e_we, e_res, e_wa} = {1'b1, w[5], r, w[4:0]};
            if (w[5]) mem[w[4:0]] = r;
            else e_acc = r;
            if (w[11:6] == cdsx_pkg::OPC_DECR_SKIP) skip = r == 8'h00;
            else e_z = r == 8'h00;
        end
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Corners: reach 01, skip on zero with a stall, then random words
    initial begin
        void'($urandom(32'h44388340));
        {e_acc, e_res, e_wa, e_z, e_sk, e_ex, e_we, skip} = '0;
        foreach (mem[i]) mem[i] = 8'h00;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        foreach (corner[i]) step(corner[i], 1'b1);
        step(12'h25F, 1'b0);
        step(12'h25F, 1'b1);
        step(12'h2C2, 1'b1);
        step(12'hFFF, 1'b1);
        repeat (3000) begin
            case ($urandom % 4)
                0: op = cdsx_pkg::OPC_INVERT;
                1: op = cdsx_pkg::OPC_DECR;
                2: op = cdsx_pkg::OPC_DECR_SKIP;
                default: op = 6'($urandom);
            endcase
            // Few addresses so values wrap down to zero and skips occur
            w_rand = {op, 1'($urandom), 5'($urandom) & 5'h11};
            step(w_rand, 1'($urandom % 4 != 0));
        end
        step(12'h000, 1'b0);
        // Mid-run reset: file, accumulator and pulses must all clear
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        {e_acc, e_res, e_wa, e_z, e_sk, e_ex, e_we, skip} = '0;
        foreach (mem[i]) mem[i] = 8'h00;
        step(12'h2C0, 1'b1);
        step(12'h000, 1'b0);
        tally_and_finish;
    end
    // Watchdog against a hung run
    initial begin
        #20000;
        bad_count++;
        tally_and_finish;
    end
endmodule
